// *** loop_bypass_consts.vh ***
// Constants for the loop path switch card mode control.
// Assumes a 40 MHz clock and a 32-bit AXI4-Lite register bus.
`ifndef LOOP_BYPASS_CONSTS_VH
`define LOOP_BYPASS_CONSTS_VH

// ****************************************
// Register byte addresses
// ****************************************
`define REG_CTRL 5'h0
`define REG_STATUS 5'h4
`define REG_IRQ_STATUS 5'h8
`define REG_IRQ_ENABLE 5'hc
`define REG_IRQ_CLEAR 5'h10

// ****************************************
// Modes
// ****************************************
`define MODE_AUTO 2'h0
`define MODE_INLINE 2'h1
`define MODE_BYPASS 2'h2
`define MODE_OPEN 2'h3

// ****************************************
// Jumper codes
// ****************************************
`define JUMPER_AUTO 2'h0
`define JUMPER_INLINE 2'h1

// ****************************************
// Path states
// ****************************************
`define PATH_BYPASS 2'h0
`define PATH_INLINE 2'h1
`define PATH_OPEN 2'h2

// ****************************************
// Interrupt bits
// ****************************************
`define IRQ_PATH_CHANGE 0
`define IRQ_POWER_LOSS 1
`define IRQ_BUTTON_RESET 2
`define IRQ_WIDTH 3

// ****************************************
// AXI responses
// ****************************************
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2

// ****************************************
// Timing
// ****************************************
`define CLK_HZ 40000000
`define HOLD_SECONDS 10
`define FLASH_MS 500

`endif

// *** hold_timer.v ***
// Counts consecutive cycles that a level stands high and pulses once when the
// count is reached. Assumes the input is synchronous to clk.
`timescale 1ns/1ps
module hold_timer #(
    parameter WIDTH = 32,
    parameter [WIDTH-1:0] COUNT = 32'd400000000
) (
    input wire aclk,
    input wire aresetn,
    input wire level,
    output reg done
);
    reg [WIDTH-1:0] count;
    reg fired;

    always @(posedge aclk) begin
        if (!aresetn) begin
            count <= {WIDTH{1'b0}};
            fired <= 1'b0;
            done <= 1'b0;
        end else begin
            done <= 1'b0;
            if (!level) begin
                count <= {WIDTH{1'b0}};
                fired <= 1'b0;
            end else if (!fired) begin
                if (count >= COUNT - 1'b1) begin
                    done <= 1'b1;
                    fired <= 1'b1;
                end else begin
                    count <= count + 1'b1;
                end
            end
        end
    end
endmodule

// *** presence_filter.v ***
// Registers a connector presence level and flags its falling edge.
// Assumes the sense input is synchronous to clk.
`timescale 1ns/1ps
module presence_filter (
    input wire aclk,
    input wire aresetn,
    input wire sense,
    output reg present,
    output reg lost
);
    always @(posedge aclk) begin
        if (!aresetn) begin
            present <= 1'b0;
            lost <= 1'b0;
        end else begin
            present <= sense;
            lost <= present & ~sense;
        end
    end
endmodule

// *** loop_path_switch_card.v ***
// Mode control and path switching for one loop path switch card.
// Assumes synchronous connector power senses, jumpers and buttons, and an AXI4-Lite master.
`timescale 1ns/1ps
`include "loop_bypass_consts.vh"
module loop_path_switch_card #(
    parameter HOLD_CYCLES = `CLK_HZ * `HOLD_SECONDS,
    parameter FLASH_CYCLES = (`CLK_HZ / 1000) * `FLASH_MS
) (
    input wire aclk,
    input wire aresetn,
    input wire [4:0] s_axi_awaddr,
    input wire s_axi_awvalid,
    output reg s_axi_awready,
    input wire [31:0] s_axi_wdata,
    input wire [3:0] s_axi_wstrb,
    input wire s_axi_wvalid,
    output reg s_axi_wready,
    output reg [1:0] s_axi_bresp,
    output reg s_axi_bvalid,
    input wire s_axi_bready,
    input wire [4:0] s_axi_araddr,
    input wire s_axi_arvalid,
    output reg s_axi_arready,
    output reg [31:0] s_axi_rdata,
    output reg [1:0] s_axi_rresp,
    output reg s_axi_rvalid,
    input wire s_axi_rready,
    input wire [1:0] jumpers,
    input wire port_a_powered,
    input wire port_b_powered,
    input wire [2:0] id_buttons,
    output reg internal_join,
    output reg port_a_link,
    output reg port_b_link,
    output reg mode_led_green,
    output reg link_led_a,
    output reg link_led_b,
    output reg display_flash,
    output reg irq
);
    // ****************************************
    // Presence and button timing
    // ****************************************
    localparam [31:0] HOLD_COUNT = HOLD_CYCLES;
    localparam [31:0] FLASH_COUNT = FLASH_CYCLES;
    wire present_a;
    wire present_b;
    wire lost_a;
    wire lost_b;
    wire button_reset;

    presence_filter filter_a (
        .aclk(aclk),
        .aresetn(aresetn),
        .sense(port_a_powered),
        .present(present_a),
        .lost(lost_a)
    );
    presence_filter filter_b (
        .aclk(aclk),
        .aresetn(aresetn),
        .sense(port_b_powered),
        .present(present_b),
        .lost(lost_b)
    );
    hold_timer #(.WIDTH(32), .COUNT(HOLD_COUNT)) button_timer (
        .aclk(aclk),
        .aresetn(aresetn),
        .level(&id_buttons),
        .done(button_reset)
    );

    // ****************************************
    // Mode selection
    // ****************************************
    reg [1:0] soft_mode;
    reg [1:0] path;
    reg [31:0] flash_count;
    reg [`IRQ_WIDTH-1:0] irq_status;
    reg [`IRQ_WIDTH-1:0] irq_enable;
    reg [1:0] next_path;
    wire jumper_inline = (jumpers == `JUMPER_INLINE);
    wire [1:0] mode = jumper_inline ? `MODE_INLINE : soft_mode;
    wire any_present = present_a | present_b;

    always @* begin
        case (mode)
            `MODE_INLINE: next_path = `PATH_INLINE;
            `MODE_BYPASS: next_path = `PATH_BYPASS;
            `MODE_OPEN: next_path = `PATH_OPEN;
            // Re-evaluated every cycle, power lost on both ports drops to bypass
            default: next_path = any_present ? `PATH_INLINE : `PATH_BYPASS;
        endcase
    end

    // ****************************************
    // Register bus
    // ****************************************
    reg [4:0] aw_addr;
    reg aw_held;
    reg [31:0] w_data;
    reg [3:0] w_strb;
    reg w_held;
    wire do_write = aw_held & w_held & ~s_axi_bvalid;
    wire wr_ctrl = do_write & (aw_addr == `REG_CTRL) & w_strb[0];
    wire wr_enable = do_write & (aw_addr == `REG_IRQ_ENABLE) & w_strb[0];
    wire wr_clear = do_write & (aw_addr == `REG_IRQ_CLEAR) & w_strb[0];
    wire path_change = (next_path != path);
    wire [`IRQ_WIDTH-1:0] irq_events = {button_reset, (lost_a | lost_b) & (mode == `MODE_AUTO), path_change};
    reg write_known;
    reg [31:0] read_word;
    reg read_err;

    // ****************************************
    // Address decode
    // ****************************************
    // Only the writable offsets answer OKAY
    always @* begin
        write_known = 1'b0;
        if (aw_addr == `REG_CTRL)
            write_known = 1'b1;
        else if (aw_addr == `REG_IRQ_ENABLE)
            write_known = 1'b1;
        else if (aw_addr == `REG_IRQ_CLEAR)
            write_known = 1'b1;
    end

    // Unmapped offsets read zero with a slave error
    always @* begin
        read_word = 32'h0;
        read_err = 1'b0;
        if (s_axi_araddr == `REG_CTRL)
            read_word = {30'h0, soft_mode};
        else if (s_axi_araddr == `REG_STATUS)
            read_word = {24'h0, present_b, present_a, jumper_inline, display_flash, path, mode};
        else if (s_axi_araddr == `REG_IRQ_STATUS)
            read_word = {29'h0, irq_status};
        else if (s_axi_araddr == `REG_IRQ_ENABLE)
            read_word = {29'h0, irq_enable};
        else if (s_axi_araddr == `REG_IRQ_CLEAR)
            read_word = 32'h0;
        else
            read_err = 1'b1;
    end

    always @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_awready <= 1'b1;
            s_axi_wready <= 1'b1;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= `RESP_OKAY;
            aw_held <= 1'b0;
            w_held <= 1'b0;
            aw_addr <= 5'h0;
            w_data <= 32'h0;
            w_strb <= 4'h0;
        end else begin
            if (s_axi_awvalid & s_axi_awready) begin
                aw_addr <= s_axi_awaddr;
                aw_held <= 1'b1;
                s_axi_awready <= 1'b0;
            end
            if (s_axi_wvalid & s_axi_wready) begin
                w_data <= s_axi_wdata;
                w_strb <= s_axi_wstrb;
                w_held <= 1'b1;
                s_axi_wready <= 1'b0;
            end
            if (do_write) begin
                s_axi_bvalid <= 1'b1;
                s_axi_bresp <= write_known ? `RESP_OKAY : `RESP_SLVERR;
            end
            if (s_axi_bvalid & s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
                aw_held <= 1'b0;
                w_held <= 1'b0;
                s_axi_awready <= 1'b1;
                s_axi_wready <= 1'b1;
            end
        end
    end

    always @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_arready <= 1'b1;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h0;
            s_axi_rresp <= `RESP_OKAY;
        end else if (s_axi_rvalid) begin
            if (s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
                s_axi_arready <= 1'b1;
            end
        end else if (s_axi_arvalid & s_axi_arready) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b1;
            s_axi_rdata <= read_word;
            s_axi_rresp <= read_err ? `RESP_SLVERR : `RESP_OKAY;
        end
    end

    // ****************************************
    // Mode state, paths and lights
    // ****************************************
    reg next_internal_join;
    reg next_port_link;
    reg next_mode_led;
    reg next_link_led_a;
    reg next_link_led_b;

    always @* begin
        next_internal_join = 1'b0;
        next_port_link = 1'b0;
        next_mode_led = (mode == `MODE_INLINE);
        next_link_led_a = 1'b0;
        next_link_led_b = 1'b0;
        case (next_path)
            // Bypass joins both strings so all slots chain internally
            `PATH_BYPASS: next_internal_join = 1'b1;
            `PATH_INLINE: begin
                next_port_link = 1'b1;
                next_link_led_a = present_a & ~next_mode_led;
                next_link_led_b = present_b & ~next_mode_led;
            end
            // Open leaves every path inactive
            default: next_port_link = 1'b0;
        endcase
    end

    always @(posedge aclk) begin
        if (!aresetn) begin
            soft_mode <= `MODE_AUTO;
            path <= `PATH_BYPASS;
            internal_join <= 1'b0;
            port_a_link <= 1'b0;
            port_b_link <= 1'b0;
            mode_led_green <= 1'b0;
            link_led_a <= 1'b0;
            link_led_b <= 1'b0;
        end else begin
            // Per-card storage only; no sharing between cards
            if (button_reset)
                soft_mode <= `MODE_AUTO;
            else if (wr_ctrl && !jumper_inline)
                soft_mode <= w_data[1:0];
            path <= next_path;
            internal_join <= next_internal_join;
            port_a_link <= next_port_link;
            port_b_link <= next_port_link;
            mode_led_green <= next_mode_led;
            link_led_a <= next_link_led_a;
            link_led_b <= next_link_led_b;
        end
    end

    // ****************************************
    // Display flash after a button reset
    // ****************************************
    always @(posedge aclk) begin
        if (!aresetn) begin
            flash_count <= 32'h0;
            display_flash <= 1'b0;
        end else if (button_reset) begin
            display_flash <= 1'b1;
            flash_count <= FLASH_COUNT;
        end else if (flash_count != 32'h0) begin
            flash_count <= flash_count - 32'h1;
            display_flash <= (flash_count != 32'h1);
        end
    end

    // ****************************************
    // Interrupts
    // ****************************************
    wire [`IRQ_WIDTH-1:0] clear_mask = wr_clear ? w_data[`IRQ_WIDTH-1:0] : {`IRQ_WIDTH{1'b0}};
    // Set wins over a clear in the same cycle
    wire [`IRQ_WIDTH-1:0] next_irq_status = (irq_status & ~clear_mask) | irq_events;

    always @(posedge aclk) begin
        if (!aresetn) begin
            irq_status <= {`IRQ_WIDTH{1'b0}};
            irq_enable <= {`IRQ_WIDTH{1'b0}};
            irq <= 1'b0;
        end else begin
            if (wr_enable)
                irq_enable <= w_data[`IRQ_WIDTH-1:0];
            irq_status <= next_irq_status;
            irq <= |(irq_status & irq_enable);
        end
    end
endmodule

// *** lbm_properties.sv ***
// Checker for the loop path switch card, bound to its top-level ports.
// Assumes one clock domain and a synchronous active-low reset.
`timescale 1ns/1ps
module lbm_properties (
    input wire aclk,
    input wire aresetn,
    input wire [1:0] jumpers,
    input wire port_a_powered,
    input wire port_b_powered,
    input wire internal_join,
    input wire port_a_link,
    input wire port_b_link,
    input wire mode_led_green,
    input wire link_led_a,
    input wire link_led_b,
    input wire s_axi_arvalid,
    input wire s_axi_arready,
    input wire s_axi_rvalid,
    input wire s_axi_rready,
    input wire [31:0] s_axi_rdata,
    input wire s_axi_bvalid,
    input wire s_axi_bready,
    input wire [1:0] s_axi_bresp
);
    // ****************************************
    // Properties
    // ****************************************
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);
    a_inline_leds_off: assert property (mode_led_green |-> !link_led_a && !link_led_b)
        else $error("link lights on in forced inline");
    a_inline_no_join: assert property (mode_led_green [*2] |-> !internal_join)
        else $error("strings joined in forced inline");
    a_join_excludes_link: assert property (internal_join |-> !port_a_link && !port_b_link)
        else $error("join and link at once");
    a_jumper_forces: assert property ((jumpers == 2'h1) [*3] |-> mode_led_green)
        else $error("jumpered inline not shown");
    a_no_power_closed: assert property ((!port_a_powered && !port_b_powered && !mode_led_green) [*3]
        |-> !port_a_link && !port_b_link)
        else $error("link kept without power");
    a_bresp_holds: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
        else $error("write response dropped");
    a_rdata_holds: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
        else $error("read data dropped");
    a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
        else $error("read not answered");
endmodule
bind loop_path_switch_card lbm_properties u_lbm_properties (.aclk, .aresetn, .jumpers, .port_a_powered,
    .port_b_powered, .internal_join, .port_a_link, .port_b_link, .mode_led_green, .link_led_a, .link_led_b,
    .s_axi_arvalid, .s_axi_arready, .s_axi_rvalid, .s_axi_rready, .s_axi_rdata, .s_axi_bvalid,
    .s_axi_bready, .s_axi_bresp);

// *** host_adapter_model.sv ***
// Host attachments on the two external connectors, seen as power senses.
// Assumes the bench commands power per connector; the sense lags by two edges.
`timescale 1ns/1ps
module host_adapter_model (
    input wire aclk,
    input wire [1:0] power_on,
    output reg port_a_powered = 1'b0,
    output reg port_b_powered = 1'b0
);
    // Motor start pacing stays inside the host and never reaches these pins
    reg [1:0] lag = 2'h0;
    always @(posedge aclk) begin
        lag <= power_on;
        {port_b_powered, port_a_powered} <= lag;
    end
endmodule

// *** loop_path_switch_card_tb.sv ***
// Self-checking bench for the loop path switch card.
// Assumes short hold and flash counts set by parameter.
`timescale 1ns/1ps
`include "loop_bypass_consts.vh"
module loop_path_switch_card_tb;
    reg aclk = 0, aresetn = 0, s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
    reg s_axi_arvalid = 0, s_axi_rready = 0;
    reg [4:0] s_axi_awaddr = 5'h0, s_axi_araddr = 5'h0;
    reg [31:0] s_axi_wdata = 32'h0, d;
    reg [1:0] jumpers = 2'h0, power_on = 2'h0, r;
    reg [2:0] id_buttons = 3'h0;
    wire s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, irq, display_flash;
    wire [1:0] s_axi_bresp, s_axi_rresp;
    wire [31:0] s_axi_rdata;
    wire internal_join, port_a_link, port_b_link, mode_led_green, link_led_a, link_led_b;
    wire port_a_powered, port_b_powered;
    wire [5:0] outs = {internal_join, port_a_link, port_b_link, mode_led_green, link_led_a, link_led_b};
    integer fail_count = 0, n_checks = 0, i;
    loop_path_switch_card #(.HOLD_CYCLES(20), .FLASH_CYCLES(5)) u_loop_path_switch_card (.aclk, .aresetn,
        .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb(4'hf), .s_axi_wvalid,
        .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
        .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .jumpers,
        .port_a_powered, .port_b_powered, .id_buttons, .internal_join, .port_a_link, .port_b_link,
        .mode_led_green, .link_led_a, .link_led_b, .display_flash, .irq);
    host_adapter_model u_host_adapter_model (.aclk, .power_on, .port_a_powered, .port_b_powered);
    // ****************************************
    // Bus and check tasks
    // ****************************************
    task chk(input [31:0] got, input [31:0] exp);
        begin
            n_checks = n_checks + 1;
            if (got !== exp) begin
                fail_count = fail_count + 1;
                $display("mismatch at %0t: got %h expected %h", $time, got, exp);
            end
        end
    endtask
    task wr(input [4:0] a, input [31:0] v);
        reg da, dw;
        begin
            da = 0;
            dw = 0;
            @(posedge aclk);
            s_axi_awaddr <= a;
            s_axi_wdata <= v;
            s_axi_awvalid <= 1;
            s_axi_wvalid <= 1;
            s_axi_bready <= 1;
            while (!(da && dw)) begin
                @(posedge aclk);
                if (!da && s_axi_awready) begin
                    da = 1;
                    s_axi_awvalid <= 0;
                end
                if (!dw && s_axi_wready) begin
                    dw = 1;
                    s_axi_wvalid <= 0;
                end
            end
            do @(posedge aclk); while (!s_axi_bvalid);
            r = s_axi_bresp;
            s_axi_bready <= 0;
            repeat (4) @(posedge aclk);
        end
    endtask
    task rd(input [4:0] a);
        begin
            @(posedge aclk);
            s_axi_araddr <= a;
            s_axi_arvalid <= 1;
            s_axi_rready <= 1;
            do @(posedge aclk); while (!s_axi_arready);
            s_axi_arvalid <= 0;
            do @(posedge aclk); while (!s_axi_rvalid);
            d = s_axi_rdata;
            r = s_axi_rresp;
            s_axi_rready <= 0;
        end
    endtask
    task pw(input [1:0] v);
        begin
            @(posedge aclk);
            power_on <= v;
            repeat (6) @(posedge aclk);
        end
    endtask
    task conclude;
        begin
            $display("checks %0d mismatches %0d", n_checks, fail_count);
            if (fail_count == 0 && n_checks > 0)
                $display("Result: passed");
            else
                $display("Result: failed");
            $finish;
        end
    endtask
    // ****************************************
    // Scenarios
    // ****************************************
    task sc_auto;
        begin
            pw(2'b01);
            chk(outs, 6'h1a);
            pw(2'b00);
            chk(outs, 6'h20);
            rd(`REG_IRQ_STATUS);
            chk(d[1], 1'b1);
            pw(2'b10);
            chk(outs, 6'h19);
        end
    endtask
    task sc_forced;
        begin
            wr(`REG_CTRL, 2);
            chk(r, `RESP_OKAY);
            chk(outs, 6'h20);
            wr(`REG_CTRL, 3);
            chk(outs, 6'h00);
            wr(`REG_CTRL, 1);
            pw(2'b00);
            chk(outs, 6'h1c);
            rd(`REG_STATUS);
            chk(d[3:0], 4'h5);
        end
    endtask
    task sc_jumper;
        begin
            wr(`REG_CTRL, 0);
            pw(2'b11);
            jumpers <= `JUMPER_INLINE;
            wr(`REG_CTRL, 2);
            chk(outs, 6'h1c);
            rd(`REG_STATUS);
            chk(d[5:0], 6'h25);
            jumpers <= `JUMPER_AUTO;
            rd(`REG_CTRL);
            chk(d[1:0], 2'h0);
            repeat (4) @(posedge aclk);
            chk(outs, 6'h1b);
        end
    endtask
    task sc_irq;
        begin
            wr(`REG_IRQ_ENABLE, 7);
            chk(r, `RESP_OKAY);
            chk(irq, 1'b1);
            wr(`REG_IRQ_ENABLE, 0);
            chk(irq, 1'b0);
            wr(`REG_IRQ_CLEAR, 7);
            rd(`REG_IRQ_STATUS);
            chk(d, 0);
            rd(5'h2);
            chk(d, 0);
            chk(r, `RESP_SLVERR);
            wr(5'h14, 1);
            chk(r, `RESP_SLVERR);
            rd(`REG_CTRL);
            chk(d[1:0], `MODE_AUTO);
        end
    endtask
    task sc_button;
        begin
            wr(`REG_CTRL, 2);
            @(posedge aclk);
            id_buttons <= 3'h7;
            for (i = 0; i < 40 && !display_flash; i = i + 1)
                @(posedge aclk);
            chk(display_flash, 1'b1);
            id_buttons <= 3'h0;
            rd(`REG_CTRL);
            chk(d[1:0], `MODE_AUTO);
            rd(`REG_IRQ_STATUS);
            chk(d[2], 1'b1);
        end
    endtask
    initial forever #12.5 aclk = ~aclk;
    initial begin
        repeat (20) @(posedge aclk);
        chk(outs, 6'h00);
        chk({s_axi_awready, s_axi_wready, s_axi_arready}, 3'h7);
        aresetn <= 1;
        sc_auto;
        sc_forced;
        sc_jumper;
        sc_irq;
        sc_button;
        conclude;
    end
    initial begin
        repeat (5000) @(posedge aclk);
        fail_count = fail_count + 1;
        conclude;
    end
endmodule
